// >>> include/sfp_map.svh
// widths, depths, counts and instruction codes for the flow-through port
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH
`define SFP_ADDR_W      18
`define SFP_DATA_W      36
`define SFP_LANES       4
`define SFP_LANE_W      9
`define SFP_DEPTH       262144
`define SFP_BURST_LEN   4
`define SFP_BURST_W     2
`define SFP_BUF_DEPTH   2
`define SFP_IR_W        3
`define SFP_IR_IDCODE   3'h1
`define SFP_IR_BYPASS   3'h7
`define SFP_IR_CAPTURE  3'h1
`define SFP_IDCODE_W    32
`endif

// >>> include/sfp_pkg.sv
// types shared by the flow-through port modules
package sfp_pkg;
	typedef enum logic [1:0] {SFP_OP_IDLE, SFP_OP_READ, SFP_OP_WRITE} sfp_op_t;
	typedef struct packed {
		sfp_op_t     op;
		logic [17:0] addr;
		logic [3:0]  lane_n;
	} sfp_cmd_t;
	typedef struct packed {
		logic [17:0] addr;
		logic [35:0] data;
	} sfp_rd_word_t;
	typedef enum logic [3:0] {
		SFP_TAP_RESET, SFP_TAP_IDLE, SFP_TAP_SEL_DR, SFP_TAP_CAP_DR, SFP_TAP_SH_DR, SFP_TAP_EX1_DR,
		SFP_TAP_PAU_DR, SFP_TAP_EX2_DR, SFP_TAP_UPD_DR, SFP_TAP_SEL_IR, SFP_TAP_CAP_IR, SFP_TAP_SH_IR,
		SFP_TAP_EX1_IR, SFP_TAP_PAU_IR, SFP_TAP_EX2_IR, SFP_TAP_UPD_IR
	} sfp_tap_t;
endpackage

// >>> hdl/sfp_skid_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`include "sfp_map.svh"
module sfp_skid_buf (
	// clock and reset
	input  wire logic                       ref_clk,
	input  wire logic                       srst,
	// fill side
	input  wire sfp_pkg::sfp_rd_word_t      in_word,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	// drain side
	output sfp_pkg::sfp_rd_word_t           out_word,
	output logic                            out_valid,
	input  wire logic                       out_ready
);
	import sfp_pkg::*;

	sfp_rd_word_t slot_reg [`SFP_BUF_DEPTH];
	logic         wr_ptr_reg;
	logic         rd_ptr_reg;
	logic [1:0]   count_reg;
	logic         push;
	logic         pop;

	assign in_ready  = (count_reg != 2'h2);
	assign out_valid = (count_reg != 2'h0);
	assign out_word  = slot_reg[rd_ptr_reg];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge ref_clk) begin
		if (push) begin
			slot_reg[wr_ptr_reg] <= in_word;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

// >>> hdl/sfp_scan_tap.sv
// boundary-scan test access port, test clock sampled on ref_clk
`timescale 1ns/1ps
`include "sfp_map.svh"
module sfp_scan_tap #(
	parameter logic [31:0] IDCODE_VALUE = 32'h0000_0001 // arbitrary value
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic srst,
	// test pins
	input  wire logic tck,
	input  wire logic tms,
	input  wire logic tdi,
	output logic      tdo,
	output logic      tdo_oe_n
);
	import sfp_pkg::*;

	sfp_tap_t                 state_reg;
	sfp_tap_t                 state_next;
	logic                     tck_d_reg;
	logic [`SFP_IR_W-1:0]     ir_reg;
	logic [`SFP_IR_W-1:0]     ir_shift_reg;
	logic [`SFP_IDCODE_W-1:0] dr_shift_reg;
	logic                     rise;
	logic                     fall;

	assign rise = tck & ~tck_d_reg;
	assign fall = ~tck & tck_d_reg;

	// ----------------------------------------
	// controller state
	// ----------------------------------------
	always_comb begin
		case (state_reg)
			SFP_TAP_RESET:  state_next = tms ? SFP_TAP_RESET  : SFP_TAP_IDLE;
			SFP_TAP_IDLE:   state_next = tms ? SFP_TAP_SEL_DR : SFP_TAP_IDLE;
			SFP_TAP_SEL_DR: state_next = tms ? SFP_TAP_SEL_IR : SFP_TAP_CAP_DR;
			SFP_TAP_CAP_DR: state_next = tms ? SFP_TAP_EX1_DR : SFP_TAP_SH_DR;
			SFP_TAP_SH_DR:  state_next = tms ? SFP_TAP_EX1_DR : SFP_TAP_SH_DR;
			SFP_TAP_EX1_DR: state_next = tms ? SFP_TAP_UPD_DR : SFP_TAP_PAU_DR;
			SFP_TAP_PAU_DR: state_next = tms ? SFP_TAP_EX2_DR : SFP_TAP_PAU_DR;
			SFP_TAP_EX2_DR: state_next = tms ? SFP_TAP_UPD_DR : SFP_TAP_SH_DR;
			SFP_TAP_UPD_DR: state_next = tms ? SFP_TAP_SEL_DR : SFP_TAP_IDLE;
			SFP_TAP_SEL_IR: state_next = tms ? SFP_TAP_RESET  : SFP_TAP_CAP_IR;
			SFP_TAP_CAP_IR: state_next = tms ? SFP_TAP_EX1_IR : SFP_TAP_SH_IR;
			SFP_TAP_SH_IR:  state_next = tms ? SFP_TAP_EX1_IR : SFP_TAP_SH_IR;
			SFP_TAP_EX1_IR: state_next = tms ? SFP_TAP_UPD_IR : SFP_TAP_PAU_IR;
			SFP_TAP_PAU_IR: state_next = tms ? SFP_TAP_EX2_IR : SFP_TAP_PAU_IR;
			SFP_TAP_EX2_IR: state_next = tms ? SFP_TAP_UPD_IR : SFP_TAP_SH_IR;
			SFP_TAP_UPD_IR: state_next = tms ? SFP_TAP_SEL_DR : SFP_TAP_IDLE;
			default:        state_next = SFP_TAP_RESET;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_reg <= SFP_TAP_RESET;
			tck_d_reg <= 1'b0;
		end else begin
			tck_d_reg <= tck;
			if (rise) begin
				state_reg <= state_next;
			end
		end
	end

	// ----------------------------------------
	// instruction and data shift paths
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ir_reg       <= `SFP_IR_IDCODE;
			ir_shift_reg <= '0;
			dr_shift_reg <= '0;
		end else if (rise) begin
			case (state_reg)
				SFP_TAP_RESET:  ir_reg <= `SFP_IR_IDCODE;
				SFP_TAP_CAP_IR: ir_shift_reg <= `SFP_IR_CAPTURE;
				SFP_TAP_SH_IR:  ir_shift_reg <= {tdi, ir_shift_reg[`SFP_IR_W-1:1]};
				SFP_TAP_UPD_IR: ir_reg <= ir_shift_reg;
				SFP_TAP_CAP_DR: dr_shift_reg <= (ir_reg == `SFP_IR_IDCODE) ? IDCODE_VALUE : '0;
				SFP_TAP_SH_DR: begin
					if (ir_reg == `SFP_IR_IDCODE) begin
						dr_shift_reg <= {tdi, dr_shift_reg[`SFP_IDCODE_W-1:1]};
					end else begin
						dr_shift_reg <= {{(`SFP_IDCODE_W-1){1'b0}}, tdi};
					end
				end
				default: ;
			endcase
		end
	end

	// test data out changes on the falling test clock edge
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tdo      <= 1'b0;
			tdo_oe_n <= 1'b1;
		end else if (fall) begin
			tdo      <= (state_reg == SFP_TAP_SH_IR) ? ir_shift_reg[0] : dr_shift_reg[0];
			tdo_oe_n <= ~((state_reg == SFP_TAP_SH_IR) | (state_reg == SFP_TAP_SH_DR));
		end
	end
endmodule

// >>> hdl/sfp_port.sv
// flow-through burst static memory port, 256K words of 36 bits
`timescale 1ns/1ps
`include "sfp_map.svh"
// Function
// - register every synchronous input on rising edge
// - clock_gate_n high freezes command, data pins and low_power; read stream and test port still run
// - back-to-back reads and writes, no waits while the read stream accepts words
// - writes update only lanes with strobe low
// - read data follows registered address next cycle
// - selected only when all three selects active
// - output enable floats data pins without clock
// - data drivers off during a write data phase, except one right after a read, whose data still drives
// - burst order linear or interleaved by mode
// - low power on sleep or deselect
// - boundary-scan test access port provided
module sfp_port #(
	parameter logic [31:0] IDCODE_VALUE = 32'h0000_0001 // arbitrary value
) (
	// clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      srst,
	// control
	input  wire logic                      clock_gate_n,
	input  wire logic [`SFP_ADDR_W-1:0]    addr,
	input  wire logic                      burst_advance_load,
	input  wire logic                      write_n,
	input  wire logic [`SFP_LANES-1:0]     byte_lane_write_n,
	input  wire logic                      chip_sel1_n,
	input  wire logic                      chip_sel2,
	input  wire logic                      chip_sel3_n,
	input  wire logic                      out_enable_n,
	input  wire logic                      burst_linear,
	input  wire logic                      sleep_request,
	// data pins
	input  wire logic [`SFP_DATA_W-1:0]    dq_in,
	output logic [`SFP_DATA_W-1:0]         dq_out,
	output logic                           dq_oe_n,
	// status
	output logic                           low_power,
	// read data stream
	output sfp_pkg::sfp_rd_word_t          rd_word,
	output logic                           rd_valid,
	input  wire logic                      rd_ready,
	// test access port
	input  wire logic                      tck,
	input  wire logic                      tms,
	input  wire logic                      tdi,
	output logic                           tdo,
	output logic                           tdo_oe_n
);
	import sfp_pkg::*;

	logic [`SFP_DATA_W-1:0]  mem [`SFP_DEPTH];
	sfp_cmd_t                cmd_reg;
	sfp_cmd_t                cmd_next;
	logic [`SFP_ADDR_W-1:0]  base_reg;
	logic [`SFP_BURST_W-1:0] burst_cnt_reg;
	logic [`SFP_BURST_W-1:0] burst_cnt_next;
	logic [`SFP_DATA_W-1:0]  dq_out_reg;
	logic                    drive_reg;
	logic                    low_power_reg;
	logic                    advance;
	logic                    selected;
	logic                    run;
	logic                    buf_in_ready;
	logic                    buf_push;
	sfp_rd_word_t            buf_in_word;

	// ----------------------------------------
	// burst address order
	// ----------------------------------------
	function automatic logic [`SFP_BURST_W-1:0] burst_low(
		input logic [`SFP_BURST_W-1:0] start,
		input logic [`SFP_BURST_W-1:0] step,
		input logic                    linear
	);
		burst_low = linear ? start + step : start ^ step;
	endfunction

	// ----------------------------------------
	// cycle qualification
	// ----------------------------------------
	// a stalled read stream also holds the port, so no word is lost
	assign run      = ~clock_gate_n & buf_in_ready;
	assign selected = ~chip_sel1_n & chip_sel2 & ~chip_sel3_n;
	assign advance  = burst_advance_load;

	always_comb begin
		cmd_next       = cmd_reg;
		burst_cnt_next = burst_cnt_reg;
		if (sleep_request) begin
			cmd_next.op    = SFP_OP_IDLE;
			burst_cnt_next = '0;
		end else if (advance) begin
			burst_cnt_next      = burst_cnt_reg + 2'h1;
			cmd_next.addr       = {base_reg[`SFP_ADDR_W-1:`SFP_BURST_W],
				burst_low(base_reg[`SFP_BURST_W-1:0], burst_cnt_next, burst_linear)};
			cmd_next.lane_n     = byte_lane_write_n;
		end else begin
			burst_cnt_next  = '0;
			cmd_next.addr   = addr;
			cmd_next.lane_n = byte_lane_write_n;
			if (!selected) begin
				cmd_next.op = SFP_OP_IDLE;
			end else if (!write_n) begin
				cmd_next.op = SFP_OP_WRITE;
			end else begin
				cmd_next.op = SFP_OP_READ;
			end
		end
	end

	// ----------------------------------------
	// input registers
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cmd_reg       <= '{op: SFP_OP_IDLE, addr: '0, lane_n: '1};
			base_reg      <= '0;
			burst_cnt_reg <= '0;
		end else if (run) begin
			cmd_reg       <= cmd_next;
			burst_cnt_reg <= burst_cnt_next;
			if (!advance) begin
				base_reg <= addr;
			end
		end
	end

	// ----------------------------------------
	// array access
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (run && cmd_reg.op == SFP_OP_WRITE) begin
			for (int lane = 0; lane < `SFP_LANES; lane++) begin
				if (!cmd_reg.lane_n[lane]) begin
					mem[cmd_reg.addr][lane*`SFP_LANE_W +: `SFP_LANE_W] <=
						dq_in[lane*`SFP_LANE_W +: `SFP_LANE_W];
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			dq_out_reg <= '0;
			drive_reg  <= 1'b0;
		end else if (run) begin
			drive_reg <= (cmd_reg.op == SFP_OP_READ);
			if (cmd_reg.op == SFP_OP_READ) begin
				dq_out_reg <= mem[cmd_reg.addr];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			low_power_reg <= 1'b1;
		end else if (run) begin
			low_power_reg <= sleep_request | (cmd_next.op == SFP_OP_IDLE);
		end
	end

	// ----------------------------------------
	// pins
	// ----------------------------------------
	assign dq_out    = dq_out_reg;
	// output enable acts without waiting for an edge
	assign dq_oe_n   = ~drive_reg | out_enable_n;
	assign low_power = low_power_reg;

	// ----------------------------------------
	// read data stream
	// ----------------------------------------
	assign buf_push         = run & (cmd_reg.op == SFP_OP_READ);
	assign buf_in_word.addr = cmd_reg.addr;
	assign buf_in_word.data = mem[cmd_reg.addr];

	sfp_skid_buf u_buf (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.in_word   (buf_in_word),
		.in_valid  (buf_push),
		.in_ready  (buf_in_ready),
		.out_word  (rd_word),
		.out_valid (rd_valid),
		.out_ready (rd_ready)
	);

	// ----------------------------------------
	// test access port
	// ----------------------------------------
	sfp_scan_tap #(
		.IDCODE_VALUE (IDCODE_VALUE)
	) u_tap (
		.ref_clk  (ref_clk),
		.srst     (srst),
		.tck      (tck),
		.tms      (tms),
		.tdi      (tdi),
		.tdo      (tdo),
		.tdo_oe_n (tdo_oe_n)
	);
endmodule

// >>> verif/sfp_rd_sink.sv
// read stream consumer standing in for the master side
`timescale 1ns/1ps
module sfp_rd_sink (
	// clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  srst,
	// read stream
	input  wire sfp_pkg::sfp_rd_word_t rd_word,
	input  wire logic                  rd_valid,
	output logic                       rd_ready,
	// control and status
	input  wire logic                  stall,
	output logic [17:0]                last_addr
);
	import sfp_pkg::*;
	// ----------
	// consumer
	// ----------
	assign rd_ready = !stall;
	always_ff @(posedge ref_clk) begin
		if (srst)
			last_addr <= 18'h00000;
		else if (rd_valid && rd_ready)
			last_addr <= rd_word.addr;
	end
endmodule

// >>> verif/sfp_port_sva.sv
// assertions on the port pins
`timescale 1ns/1ps
`include "sfp_map.svh"
module sfp_port_sva (
	// clock and reset
	input wire logic                   ref_clk,
	input wire logic                   srst,
	// control
	input wire logic                   clock_gate_n,
	input wire logic [`SFP_ADDR_W-1:0] addr,
	input wire logic                   burst_advance_load,
	input wire logic                   write_n,
	input wire logic                   chip_sel1_n,
	input wire logic                   chip_sel2,
	input wire logic                   chip_sel3_n,
	input wire logic                   out_enable_n,
	input wire logic                   sleep_request,
	input wire logic                   rd_ready,
	// outputs
	input wire logic [`SFP_DATA_W-1:0] dq_out,
	input wire logic                   dq_oe_n,
	input wire logic                   low_power,
	input wire sfp_pkg::sfp_rd_word_t  rd_word,
	input wire logic                   rd_valid,
	input wire logic                   tdo_oe_n
);
	import sfp_pkg::*;
	// ----------
	// checks
	// ----------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	logic sel, run, load;
	assign sel  = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
	assign run  = !clock_gate_n && rd_ready;
	assign load = run && !burst_advance_load && !sleep_request;
	sequence s_read;
		load && sel && write_n && $past(rd_ready) ##1 run;
	endsequence
	sequence s_write;
		load && sel && !write_n ##1 run;
	endsequence
	a_reset_quiet: assert property (disable iff (1'b0) srst |=> dq_oe_n && low_power && !rd_valid && tdo_oe_n)
		else $error("reset state wrong");
	a_read_drive: assert property (s_read |=> dq_oe_n == out_enable_n && rd_valid)
		else $error("read did not drive");
	a_read_addr: assert property (s_read |=> rd_word.addr == $past(addr, 2))
		else $error("read word address wrong");
	a_write_float: assert property (s_write |=> dq_oe_n)
		else $error("drivers on in write data phase");
	a_oe_async: assert property (out_enable_n |-> dq_oe_n)
		else $error("output enable ignored");
	a_gate_hold: assert property (clock_gate_n |=> $stable(dq_out) && $stable(low_power))
		else $error("state moved while gated");
	a_desel_power: assert property (run && (sleep_request || (!sel && !burst_advance_load)) |=> low_power)
		else $error("no low power");
	a_sel_awake: assert property (load && sel |=> !low_power)
		else $error("selected but low power");
endmodule
bind sfp_port sfp_port_sva chk_u (.ref_clk, .srst, .clock_gate_n, .addr, .burst_advance_load, .write_n,
	.chip_sel1_n, .chip_sel2, .chip_sel3_n, .out_enable_n, .sleep_request, .rd_ready, .dq_out, .dq_oe_n,
	.low_power, .rd_word, .rd_valid, .tdo_oe_n);

// >>> verif/test_sync_flowthrough_sram_port.sv
// self-checking bench for the port
`timescale 1ns/1ps
module test_sync_flowthrough_sram_port;
	import sfp_pkg::*;
	typedef struct packed {
		logic        wr;
		logic [17:0] addr;
		logic [3:0]  lanes;
		logic [35:0] data;
	} sfp_row_t;
	logic ref_clk, srst, clock_gate_n, burst_advance_load, write_n, chip_sel1_n, chip_sel2, chip_sel3_n;
	logic out_enable_n, burst_linear, sleep_request, stall, dq_oe_n, low_power, rd_valid, rd_ready;
	logic tck, tms, tdi, tdo, tdo_oe_n;
	logic [17:0]  addr, last_addr;
	logic [3:0]   byte_lane_write_n;
	logic [35:0]  dq_in, dq_out;
	sfp_rd_word_t rd_word;
	int           error_cnt = 0;
	int           n_checks = 0;
	sfp_row_t     rows [12] = '{'{1, 18'h20, 4'h0, 36'hB00}, '{1, 18'h21, 4'h0, 36'hB01},
		'{1, 18'h22, 4'h0, 36'hB02}, '{1, 18'h23, 4'h0, 36'hB03}, '{1, 18'h10, 4'h0, 36'h123456789},
		'{1, 18'h11, 4'h0, 36'hFEDCBA987}, '{0, 18'h10, 4'hF, 36'h123456789},
		'{1, 18'h10, 4'hA, 36'hFFFFFFFFF}, '{0, 18'h10, 4'hF, 36'h127FD67FF},
		'{0, 18'h11, 4'hF, 36'hFEDCBA987}, '{1, 18'h3FFFF, 4'h0, 36'hA5A5A5A5A},
		'{0, 18'h3FFFF, 4'hF, 36'hA5A5A5A5A}};
	// ----------
	// harness
	// ----------
	sfp_port dut_u (.ref_clk, .srst, .clock_gate_n, .addr, .burst_advance_load, .write_n, .byte_lane_write_n,
		.chip_sel1_n, .chip_sel2, .chip_sel3_n, .out_enable_n, .burst_linear, .sleep_request, .dq_in, .dq_out,
		.dq_oe_n, .low_power, .rd_word, .rd_valid, .rd_ready, .tck, .tms, .tdi, .tdo, .tdo_oe_n);
	sfp_rd_sink sink_u (.ref_clk, .srst, .rd_word, .rd_valid, .rd_ready, .stall, .last_addr);
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic cmd(input logic s, input logic w, input logic [17:0] a, input logic ad, input logic [3:0] l);
		chip_sel1_n <= !s;
		chip_sel2 <= s;
		chip_sel3_n <= !s;
		write_n <= !w;
		addr <= a;
		burst_advance_load <= ad;
		byte_lane_write_n <= l;
	endtask
	// one test clock period, four reference clocks long
	task automatic tap_step(input logic ms, input logic di);
		tms <= ms;
		tdi <= di;
		tck <= 1'b1;
		repeat (2) @(posedge ref_clk);
		tck <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_word({35'h0, got}, {35'h0, exp});
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#20000;
		error_cnt++;
		close_out();
	end
	// ----------
	// tests
	// ----------
	initial begin
		srst = 1'b1;
		clock_gate_n = 1'b0;
		out_enable_n = 1'b0;
		burst_linear = 1'b1;
		sleep_request = 1'b0;
		stall = 1'b0;
		dq_in = 36'h0;
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		cmd(0, 0, 18'h0, 0, 4'hF);
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		#1 chk_bit(low_power, 1'b1);
		chk_bit(dq_oe_n, 1'b1);
		chk_bit(rd_valid, 1'b0);
		$display("reset done");
		for (int i = 0; i < 14; i++) begin
			@(posedge ref_clk);
			if (i < 12)
				cmd(1, rows[i].wr, rows[i].addr, 0, rows[i].lanes);
			else
				cmd(0, 0, 18'h0, 0, 4'hF);
			if (i > 0 && i < 13)
				dq_in <= rows[i-1].data;
			#1;
			if (i > 1) begin
				chk_bit(dq_oe_n, rows[i-2].wr);
				if (!rows[i-2].wr)
					chk_word(dq_out, rows[i-2].data);
			end
		end
		$display("rows done");
		@(posedge ref_clk);
		cmd(1, 0, 18'h10, 0, 4'hF);
		@(posedge ref_clk);
		clock_gate_n <= 1'b1;
		cmd(0, 0, 18'h0, 0, 4'hF);
		repeat (3) @(posedge ref_clk);
		clock_gate_n <= 1'b0;
		#1 chk_word(dq_out, 36'hA5A5A5A5A);
		@(posedge ref_clk);
		#1 chk_word(dq_out, 36'h127FD67FF);
		$display("gate done");
		for (int m = 0; m < 2; m++) begin
			@(posedge ref_clk);
			burst_linear <= (m == 0);
			for (int i = 0; i < 6; i++) begin
				@(posedge ref_clk);
				cmd(i < 4, 0, 18'h21, i > 0 && i < 4, 4'hF);
				#1;
				if (i > 1)
					chk_word(dq_out, 36'hB00 + ((m == 0) ? ((i - 1) % 4) : (1 ^ (i - 2))));
			end
		end
		$display("burst done");
		for (int k = 0; k < 4; k++) begin
			@(posedge ref_clk);
			sleep_request <= 1'b0;
			cmd(1, 0, 18'h10, 0, 4'hF);
			@(posedge ref_clk);
			chip_sel1_n <= (k == 0);
			chip_sel2 <= (k != 1);
			chip_sel3_n <= (k == 2);
			sleep_request <= (k == 3);
			#1 chk_bit(low_power, 1'b0);
			@(posedge ref_clk);
			#1 chk_bit(low_power, 1'b1);
		end
		sleep_request <= 1'b0;
		$display("power done");
		@(posedge ref_clk);
		cmd(1, 0, 18'h3FFFF, 0, 4'hF);
		@(posedge ref_clk);
		cmd(0, 0, 18'h0, 0, 4'hF);
		@(posedge ref_clk);
		out_enable_n <= 1'b1;
		#1 chk_bit(dq_oe_n, 1'b1);
		@(posedge ref_clk);
		out_enable_n <= 1'b0;
		$display("oe done");
		@(posedge ref_clk);
		stall <= 1'b1;
		cmd(1, 0, 18'h20, 0, 4'hF);
		@(posedge ref_clk);
		cmd(1, 0, 18'h21, 0, 4'hF);
		@(posedge ref_clk);
		cmd(1, 0, 18'h22, 0, 4'hF);
		repeat (4) @(posedge ref_clk);
		#1 chk_bit(rd_valid, 1'b1);
		chk_word(rd_word.data, 36'hB00);
		@(posedge ref_clk);
		stall <= 1'b0;
		repeat (2) @(posedge ref_clk);
		cmd(0, 0, 18'h0, 0, 4'hF);
		repeat (5) @(posedge ref_clk);
		#1 chk_bit(rd_valid, 1'b0);
		chk_word({18'h0, last_addr}, 36'h22);
		$display("stall done");
		@(posedge ref_clk);
		tap_step(1'b0, 1'b0);
		tap_step(1'b1, 1'b0);
		tap_step(1'b0, 1'b0);
		tap_step(1'b0, 1'b0);
		#1 chk_bit(tdo_oe_n, 1'b0);
		chk_bit(tdo, 1'b1);
		@(posedge ref_clk);
		tap_step(1'b0, 1'b0);
		#1 chk_bit(tdo, 1'b0);
		$display("tap done");
		close_out();
	end
endmodule
